// ---- logic/scg_control.sv ----
/*
  scan control word receiver and output option decode.
  assumes the serial pins are synchronous to core_clk and sampled many times
  per serial bit; data is taken on the falling serial clock edge while the
  frame select is low.
*/
`timescale 1ns/1ps
// How it works
// RULE1 - control word is a 16-bit frame with zero top address nibble
// RULE2 - msb enable one drives the msb pin
// RULE3 - msb enable zero releases the msb pin
// RULE4 - host writes ones into reserved bits seven, six, four, one, zero
// RULE5 - step source one advances only on external trigger edges
// RULE6 - step source zero advances on the internal interval timer
// RULE7 - marker mode matters only while the marker pin is enabled
// RULE8 - level mode raises marker at scan end, drops it at next start
// RULE9 - pulse mode gives a four-clock pulse per step, nothing at scan end
// RULE10 - marker enable one drives the marker pin
// RULE11 - marker enable zero releases the marker pin
// RULE12 - new fields apply on the clock after the whole word arrives
module scg_control (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  // serial write port
  input  wire logic                         ser_sclk,
  input  wire logic                         ser_sdata,
  input  wire logic                         ser_fsync_n,
  // scan engine events
  input  wire logic                         step_timer_done,
  input  wire logic                         step_trigger_pin,
  input  wire logic                         scan_finished,
  input  wire logic                         scan_start,
  input  wire logic                         msb_level,
  // step request to the scan engine
  output logic                              step_advance,
  // msb digital pin
  output logic                              msb_digital_pin_o,
  output logic                              msb_digital_pin_oe,
  // sync marker pin
  output logic                              scan_marker_pin_o,
  output logic                              scan_marker_pin_oe,
  // control word status
  output logic [scg_pkg::CTRL_WIDTH-1:0]    scan_control_word,
  output logic                              reserved_bits_ok
);
  import scg_pkg::*;

  scg_state_type             state_ff;
  scg_state_type             nxt_state;
  logic [FRAME_BITS-1:0]     shift_ff;
  logic [FRAME_BITS-1:0]     nxt_shift;
  logic [4:0]                cnt_ff;
  logic [4:0]                nxt_cnt;
  logic [CTRL_WIDTH-1:0]     ctrl_ff;
  logic [CTRL_WIDTH-1:0]     nxt_ctrl;
  logic                      sclk_prev_ff;
  logic                      trig_prev_ff;
  logic                      msb_ff;
  logic                      sclk_fall;
  logic                      trig_rise;
  logic                      addr_is_ctrl;
  logic                      scan_marker_output;

  // serial clock falling edge, only counted inside a frame
  assign sclk_fall    = sclk_prev_ff && !ser_sclk && !ser_fsync_n;
  assign addr_is_ctrl = (shift_ff[ADDR_MSB:ADDR_LSB] == CTRL_ADDR);

  // frame receiver: shift sixteen bits msb first, then hold in load until frame select rises
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_cnt   = cnt_ff;
    nxt_ctrl  = ctrl_ff;
    unique case (state_ff)
      SCG_IDLE: begin
        nxt_cnt = 5'h00;
        if (!ser_fsync_n) begin
          nxt_state = SCG_SHIFT;
        end
      end
      SCG_SHIFT: begin
        if (ser_fsync_n) begin
          nxt_state = SCG_IDLE;                          // short frame is dropped
        end else if (sclk_fall) begin
          nxt_shift = {shift_ff[FRAME_BITS-2:0], ser_sdata};
          nxt_cnt   = cnt_ff + 5'h01;
          if (cnt_ff == 5'(FRAME_BITS - 1)) begin
            nxt_state = SCG_LOAD;                        // RULE1
          end
        end
      end
      SCG_LOAD: begin
        // whole word held; apply only if it is addressed to control
        if (addr_is_ctrl) begin
          nxt_ctrl = shift_ff[CTRL_WIDTH-1:0];           // RULE1 RULE12
        end
        nxt_cnt   = 5'h00;
        nxt_state = ser_fsync_n ? SCG_IDLE : SCG_LOAD;   // wait for frame end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= SCG_IDLE;
      shift_ff <= '0;
      cnt_ff   <= 5'h00;
      ctrl_ff  <= CTRL_RESET;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
      ctrl_ff  <= nxt_ctrl;
    end
  end

  // edge history of pins and the registered msb level
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sclk_prev_ff <= 1'b1;
      trig_prev_ff <= 1'b0;
      msb_ff       <= 1'b0;
    end else begin
      sclk_prev_ff <= ser_sclk;
      trig_prev_ff <= step_trigger_pin;
      msb_ff       <= msb_level;
    end
  end

  // step source: the timer is ignored in external mode so a stray interval
  // never advances a scan the host wants to pace by hand
  assign trig_rise    = step_trigger_pin && !trig_prev_ff;
  assign step_advance = ctrl_ff[STEP_SRC_BIT] ? trig_rise        // RULE5
                                              : step_timer_done; // RULE6

  scg_marker #(
    .PULSE_CYCLES (SYNC_PULSE_CYCLES)
  ) u_marker (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .marker_mode_select (ctrl_ff[MODE_BIT]),
    .step_advance       (step_advance),
    .scan_finished      (scan_finished),
    .scan_start         (scan_start),
    .scan_marker_output (scan_marker_output)
  );

  // pin drivers; the marker only reaches the pin while enabled
  assign msb_digital_pin_o  = msb_ff;
  assign msb_digital_pin_oe = ctrl_ff[MSB_EN_BIT];                 // RULE2 RULE3
  assign scan_marker_pin_o  = ctrl_ff[MARKER_EN_BIT] && scan_marker_output; // RULE7
  assign scan_marker_pin_oe = ctrl_ff[MARKER_EN_BIT];              // RULE10 RULE11

  // status: host-visible copy and reserved-bit check
  assign scan_control_word = ctrl_ff;
  assign reserved_bits_ok  = ((ctrl_ff & RESERVED_MASK) == RESERVED_MASK); // RULE4

  // a frame is complete at the sixteenth serial clock fall inside the frame
  sequence word_done;
    state_ff == SCG_SHIFT && sclk_fall && cnt_ff == 5'(FRAME_BITS - 1);
  endsequence
  sequence ctrl_word_done;
    word_done ##1 (state_ff == SCG_LOAD && addr_is_ctrl);
  endsequence
  // frame select raised before the last bit abandons the frame
  sequence frame_cut;
    state_ff == SCG_SHIFT && ser_fsync_n;
  endsequence

  // word loading: only complete control frames reach the register
  chk_ctrl_load: assert property (@(posedge core_clk) disable iff (!rstn) // RULE12
    ctrl_word_done |=> scan_control_word == $past(shift_ff[CTRL_WIDTH-1:0]))
    else $error("control word not applied after frame");
  chk_other_addr: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    state_ff == SCG_LOAD && !addr_is_ctrl |=> $stable(scan_control_word))
    else $error("non-control frame changed control word");
  chk_no_mid_word: assert property (@(posedge core_clk) disable iff (!rstn) // RULE12
    state_ff != SCG_LOAD |=> $stable(scan_control_word))
    else $error("control word changed mid frame");
  chk_frame_cut: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    frame_cut |=> state_ff == SCG_IDLE)
    else $error("cut frame not dropped");
  chk_reserved_flag: assert property (@(posedge core_clk) disable iff (!rstn) // RULE4
    ctrl_word_done |=> reserved_bits_ok ==
      (($past(shift_ff[CTRL_WIDTH-1:0]) & RESERVED_MASK) == RESERVED_MASK))
    else $error("reserved bit status does not follow word");

  // msb pin: enable follows the word, the pin shows the registered msb level
  chk_msb_enable: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    ctrl_word_done |=> msb_digital_pin_oe == $past(shift_ff[MSB_EN_BIT]))
    else $error("msb pin enable does not follow word");
  chk_msb_off: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
    !scan_control_word[MSB_EN_BIT] |-> !msb_digital_pin_oe)
    else $error("msb pin driven while disabled");
  chk_msb_follow: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    msb_digital_pin_oe |-> msb_digital_pin_o == $past(msb_level))
    else $error("msb pin does not follow msb level");

  // step source: external trigger edges or the internal interval timer
  chk_ext_step: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
    scan_control_word[STEP_SRC_BIT] |->
      step_advance == (step_trigger_pin && !$past(step_trigger_pin)))
    else $error("external step mismatch");
  chk_int_step: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
    !scan_control_word[STEP_SRC_BIT] |-> step_advance == step_timer_done)
    else $error("internal step mismatch");

  // marker pin: enable follows the word, the marker reaches the pin only while enabled
  chk_marker_oe: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    ctrl_word_done |=> scan_marker_pin_oe == $past(shift_ff[MARKER_EN_BIT]))
    else $error("marker enable does not follow word");
  chk_marker_off: assert property (@(posedge core_clk) disable iff (!rstn) // RULE11
    !scan_control_word[MARKER_EN_BIT] |-> !scan_marker_pin_oe && !scan_marker_pin_o)
    else $error("marker pin active while disabled");
  chk_marker_drive: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    scan_control_word[MARKER_EN_BIT] |-> scan_marker_pin_o == scan_marker_output)
    else $error("enabled marker pin does not carry marker");
  chk_marker_gate: assert property (@(posedge core_clk) disable iff (!rstn) // RULE7
    scan_control_word[MARKER_EN_BIT] && step_advance && !scan_control_word[MODE_BIT] ##1
      !scan_control_word[MODE_BIT] && scan_control_word[MARKER_EN_BIT] |-> scan_marker_pin_o)
    else $error("enabled marker pin missed step pulse");
  chk_no_end_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // RULE9
    scan_control_word[MARKER_EN_BIT] && !scan_control_word[MODE_BIT] && scan_finished
      && !step_advance && !scan_marker_pin_o ##1 !scan_control_word[MODE_BIT]
      |-> !scan_marker_pin_o)
    else $error("pulse mode marker pin raised at end of scan");
endmodule : scg_control

// ---- logic/scg_marker.sv ----
/*
  sync marker generator: level from end of scan, or a short pulse per step.
  assumes event inputs are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module scg_marker #(
  parameter int unsigned PULSE_CYCLES = scg_pkg::SYNC_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // mode and events
  input  wire logic marker_mode_select,
  input  wire logic step_advance,
  input  wire logic scan_finished,
  input  wire logic scan_start,
  // marker level
  output logic      scan_marker_output
);
  import scg_pkg::*;

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic       lvl_ff;
  logic       nxt_lvl;

  // level mode holds from end of scan to next start; pulse mode counts down
  always_comb begin
    nxt_lvl = lvl_ff;
    nxt_cnt = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0;
    if (marker_mode_select) begin
      nxt_cnt = 4'h0;
      if (scan_start) begin
        nxt_lvl = 1'b0;                                  // RULE8
      end else if (scan_finished) begin
        nxt_lvl = 1'b1;                                  // RULE8
      end
    end else begin
      nxt_lvl = 1'b0;                                    // RULE9
      if (step_advance) begin
        nxt_cnt = PULSE_CYCLES[3:0];                     // RULE9
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_ff <= 4'h0;
      lvl_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end

  assign scan_marker_output = marker_mode_select ? lvl_ff : (cnt_ff != 4'h0);

  // a step in pulse mode, then four quiet cycles with no restart or mode change
  sequence step_in_pulse_mode;
    !marker_mode_select && step_advance;
  endsequence
  sequence quiet_pulse_mode;
    !marker_mode_select && !step_advance;
  endsequence
  sequence pulse_window;
    step_in_pulse_mode ##1 quiet_pulse_mode [*4] ##1 !marker_mode_select;
  endsequence

  chk_pulse_four_cycles: assert property (@(posedge core_clk) disable iff (!rstn) // RULE9
    pulse_window |-> !scan_marker_output && $past(scan_marker_output, 1)
      && $past(scan_marker_output, 4))
    else $error("marker pulse not four cycles");
  chk_pulse_starts: assert property (@(posedge core_clk) disable iff (!rstn) // RULE9
    step_in_pulse_mode ##1 !marker_mode_select |-> scan_marker_output)
    else $error("marker pulse did not start");
  chk_level_set: assert property (@(posedge core_clk) disable iff (!rstn) // RULE8
    marker_mode_select && scan_finished && !scan_start ##1 marker_mode_select
      |-> scan_marker_output)
    else $error("end of scan level not raised");
  chk_level_clear: assert property (@(posedge core_clk) disable iff (!rstn) // RULE8
    marker_mode_select && scan_start ##1 marker_mode_select |-> !scan_marker_output)
    else $error("marker level not cleared at scan start");
  chk_level_quiet: assert property (@(posedge core_clk) disable iff (!rstn) // RULE9
    !marker_mode_select && scan_finished && !step_advance && !scan_marker_output
      ##1 !marker_mode_select |-> !scan_marker_output)
    else $error("pulse mode marker raised at end of scan");
endmodule : scg_marker

// ---- logic/scg_pkg.sv ----
/*
  scan control package: serial frame layout, control fields, reset word, state codes.
  assumes one clock (core_clk, 200 MHz) and a synchronous active-low reset.
*/
package scg_pkg;
  // serial frame layout
  localparam int unsigned FRAME_BITS        = 16;
  localparam int unsigned ADDR_MSB          = 15;
  localparam int unsigned ADDR_LSB          = 12;
  localparam logic [3:0]  CTRL_ADDR         = 4'h0;
  localparam int unsigned CTRL_WIDTH        = 12;
  // control word fields
  localparam int unsigned MSB_EN_BIT        = 8;
  localparam int unsigned STEP_SRC_BIT      = 5;
  localparam int unsigned MODE_BIT          = 3;
  localparam int unsigned MARKER_EN_BIT     = 2;
  localparam logic [11:0] RESERVED_MASK     = 12'h0D3;
  // reset: reserved bits set, pins released, internal stepping, pulse mode
  localparam logic [11:0] CTRL_RESET        = 12'h0D3;
  // marker pulse length in master clock periods
  localparam int unsigned SYNC_PULSE_CYCLES = 4;
  // frame receiver states, gray along idle -> shift -> load
  typedef enum logic [1:0] {
    SCG_IDLE  = 2'h0,
    SCG_SHIFT = 2'h1,
    SCG_LOAD  = 2'h3
  } scg_state_type;
endpackage : scg_pkg

// ---- tb/scg_host.sv ----
/*
  host model: writes 16-bit serial frames into the scan control block.
  assumes the bench calls send() from one process; sclk idles high.
*/
`timescale 1ns/1ps
module scg_host (
  // clock
  input  wire logic core_clk,
  // serial write pins
  output logic      ser_sclk,
  output logic      ser_sdata,
  output logic      ser_fsync_n
);
  // pins idle with frame select high and serial clock standing still
  initial begin
    ser_sclk    = 1'b1;
    ser_sdata   = 1'b0;
    ser_fsync_n = 1'b1;
  end

  // send the top nbits of frame msb first; ph sets each sclk phase length
  task automatic send(input logic [15:0] frame, input int ph, input int nbits);
    @(posedge core_clk);
    #1 ser_fsync_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      ser_sdata = frame[i];
      repeat (ph) @(posedge core_clk);
      #1 ser_sclk = 1'b0;
      repeat (ph) @(posedge core_clk);
      #1 ser_sclk = 1'b1;
    end
    // released data line shows the inverse so a stale bit never looks valid
    ser_fsync_n = 1'b1;
    ser_sdata   = ~ser_sdata;
    @(posedge core_clk);
  endtask : send
endmodule : scg_host

// ---- tb/tb.sv ----
/*
  self-checking bench for the scan control word receiver and output options.
  assumes the host model drives the serial pins; bench drives scan events.
*/
`timescale 1ns/1ps
module tb;
  import scg_pkg::*;
  logic        core_clk, rstn, tdone, trig, fin, start, msb_lvl;
  logic        sclk, sdata, fsync_n, adv, msb_o, msb_oe, mk_o, mk_oe, ok;
  logic [11:0] word, w;
  logic        lvl, trig_q, msb_q, exp_adv;
  int          failures, cmp_count, seed, cnt;
  // corner words: reset value, all ones, reserved broken, level and pulse modes
  logic [11:0] corner [5] = '{12'h0D3, 12'hFFF, 12'h12C, 12'h0DF, 12'h1F7};

  always #2.5 core_clk = ~core_clk;

  scg_host host_inst (.core_clk(core_clk), .ser_sclk(sclk), .ser_sdata(sdata),
                      .ser_fsync_n(fsync_n));
  scg_control scg_control_inst (.core_clk(core_clk), .rstn(rstn), .ser_sclk(sclk),
    .ser_sdata(sdata), .ser_fsync_n(fsync_n), .step_timer_done(tdone),
    .step_trigger_pin(trig), .scan_finished(fin), .scan_start(start),
    .msb_level(msb_lvl), .step_advance(adv), .msb_digital_pin_o(msb_o),
    .msb_digital_pin_oe(msb_oe), .scan_marker_pin_o(mk_o), .scan_marker_pin_oe(mk_oe),
    .scan_control_word(word), .reserved_bits_ok(ok));

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // random scan traffic under one word; a reference of marker and step runs alongside
  task automatic run_window(input logic [11:0] cw);
    // a scan start clears any held level and the idle cycles drain a pulse
    @(posedge core_clk);
    #1 start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    repeat (6) @(posedge core_clk);
    cnt = 0;
    lvl = 1'b0;
    trig_q = 1'b0;
    msb_q = 1'b0;
    repeat (24) begin
      #1 tdone = $random(seed);
      trig = $random(seed);
      fin = ($random(seed) & 7) == 0;
      start = ($random(seed) & 7) == 0;
      msb_lvl = $random(seed);
      #1 exp_adv = cw[5] ? (trig & ~trig_q) : tdone;
      check("step", adv, exp_adv);
      check("marker oe", mk_oe, cw[2]);
      check("marker", mk_o, cw[2] & (cw[3] ? lvl : cnt > 0));
      check("msb oe", msb_oe, cw[8]);
      if (cw[8]) check("msb", msb_o, msb_q);
      // reference state for the next cycle; scan start beats scan end
      if (exp_adv) cnt = SYNC_PULSE_CYCLES;
      else if (cnt > 0) cnt--;
      if (start) lvl = 1'b0;
      else if (fin) lvl = 1'b1;
      trig_q = trig;
      msb_q = msb_lvl;
      @(posedge core_clk);
    end
    #1 {tdone, trig, fin, start, msb_lvl} = 5'h00;
  endtask : run_window

  // watchdog: the run needs well under a tenth of this span
  initial begin
    #300000;
    failures++;
    end_sim;
  end

  initial begin
    {core_clk, rstn, tdone, trig, fin, start, msb_lvl} = 7'h00;
    failures = 0;
    cmp_count = 0;
    seed = 32'h4fbb7b66;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    @(posedge core_clk);
    #1 check("reset word", word, CTRL_RESET);
    check("reset pins", {msb_oe, mk_oe, mk_o}, 12'h000);
    for (int f = 0; f < 16; f++) begin
      w = (f < 5) ? corner[f] : (12'($random(seed)) | RESERVED_MASK);
      host_inst.send({CTRL_ADDR, w}, 2 + f % 2, 16);
      repeat (2) @(posedge core_clk);
      #1 check("word", word, w);
      check("reserved ok", ok, (w & RESERVED_MASK) == RESERVED_MASK);
      // foreign address and a cut frame must both leave the word alone
      host_inst.send({4'h1, ~w}, 2, 16);
      host_inst.send({CTRL_ADDR, ~w}, 3, 9);
      repeat (2) @(posedge core_clk);
      #1 check("word kept", word, w);
      run_window(w);
    end
    // reset in mid-run brings back the reset word with both pins released
    @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    @(posedge core_clk);
    #1 check("mid reset word", word, CTRL_RESET);
    check("mid reset pins", {msb_oe, mk_oe, mk_o}, 12'h000);
    end_sim;
  end
endmodule : tb
